// *** rtl/acsw_defines.svh ***
`ifndef ACSW_DEFINES_SVH
`define ACSW_DEFINES_SVH

// register offsets on the plain port
`define ACSW_ADDR_W           8
`define ACSW_ADDR_STATUS      8'h02
`define ACSW_ADDR_IRQ_STAT    8'h10
`define ACSW_ADDR_IRQ_MASK    8'h11

// status word bit positions
`define ACSW_B_BUSY           0
`define ACSW_B_JOG_OK         1
`define ACSW_B_DIRECT_OK      2
`define ACSW_B_STOP_IN        4
`define ACSW_B_GRP_STOP       5
`define ACSW_B_ALL_STOP       6
`define ACSW_B_HSPTP_ACK      7
`define ACSW_B_START_INV      8
`define ACSW_B_DEVACK_FAIL    9
`define ACSW_B_STOP_EXEC      12
`define ACSW_B_POS_DONE       13
`define ACSW_STATUS_RESET     16'h0000

// interrupt status / mask bit positions
`define ACSW_IRQ_W            6
`define ACSW_I_START_INV      0
`define ACSW_I_DEVACK_FAIL    1
`define ACSW_I_STOP_EXEC      2
`define ACSW_I_POS_DONE       3
`define ACSW_I_HSPTP_ACK      4
`define ACSW_I_STOP_IN        5
`define ACSW_IRQ_RESET        6'h00

// deviation-counter reset acknowledge wait
`define ACSW_CLK_NS           4
`define ACSW_DEVACK_WAIT_NS   100000
`define ACSW_DEVACK_CYC       ((`ACSW_DEVACK_WAIT_NS + `ACSW_CLK_NS - 1) / `ACSW_CLK_NS)

`endif

// *** rtl/acsw_pkg.sv ***
package acsw_pkg;

   // state reported by the motion generator, same clock
   typedef struct packed {
      logic busy;
      logic memory_op;
      logic axis_assigned;
      logic jog_ok;
      logic direct_ok;
      logic manual_mode;
      logic direct_mode;
      logic origin_search;
      logic grp_stop_bit;
      logic all_stop_bit;
      logic sys_stopped;
   } acsw_motion_t;

   // one-cycle events from the motion generator and command decoder
   typedef struct packed {
      logic start_req;
      logic hs_ptp;
      logic cond_fail;
      logic start_error;
      logic prio_conflict;
      logic imm_stop_cmd;
      logic dec_stop_cmd;
      logic dev_reset_out;
      logic halted;
      logic halt_decel;
      logic halt_dev_reset;
      logic halt_servo_unlock;
      logic halt_error;
      logic move_done;
      logic done_positioning;
      logic done_origin_search;
      logic done_origin_return;
      logic jog_stopped;
   } acsw_event_t;

   typedef struct packed {
      logic [1:0] unused15;
      logic       pos_done;
      logic       stop_exec;
      logic [1:0] unused11;
      logic       devack_fail;
      logic       start_inv;
      logic       hsptp_ack;
      logic       all_stop;
      logic       grp_stop;
      logic       stop_in;
      logic       unused3;
      logic       direct_ok;
      logic       jog_ok;
      logic       busy;
   } acsw_status_t;

   typedef enum logic [0:0] {ACSW_ACK_IDLE, ACSW_ACK_WAIT} acsw_ack_state_t;

endpackage

// *** rtl/acsw_top.sv ***
// Local design decision: the plain strobed port.
`timescale 1ns/1ns
`include "acsw_defines.svh"
// Summary of operation
// RULE_01: busy bit 0 is high while the axis carries out an operation.
// RULE_02: in memory operation, an unassigned axis also shows busy.
// RULE_03: bit 1 high while a jog may be started.
// RULE_04: bit 2 high while a direct operation may be started.
// RULE_05: bit 4 set by stop commands taken or by emergency or deceleration inputs.
// RULE_06: no start request is taken while bit 4 is set.
// RULE_07: bit 5 follows the group-stop command, and holds once taken and stopped.
// RULE_08: bit 6 follows the stop-all command, and holds once taken and stopped.
// RULE_09: bit 7 acknowledges a taken high-speed point-to-point start.
// RULE_10: bit 8 set when a start fails its starting conditions.
// RULE_11: bit 8 also set on a start error or a priority conflict.
// RULE_12: bit 9 set when a deviation reset in origin search goes unacknowledged.
// RULE_13: bit 12 set on manual/direct halt by decel stop, deviation reset or unlock.
// RULE_14: bit 12 also set when motion halts on an error.
// RULE_15: bit 13 set when direct positioning, origin search or return finishes.
// RULE_16: bit 13 also set when a direct-mode jog is stopped.
// RULE_17: bits 3, 10, 11, 14 and 15 always read zero.
module acsw_top #(
   parameter int unsigned DEVACK_CYC = `ACSW_DEVACK_CYC
) (
   input  wire logic                      clock,
   input  wire logic                      rstn,
   input  wire acsw_pkg::acsw_motion_t    motion,
   input  wire acsw_pkg::acsw_event_t     ev,
   input  wire logic                      estop_pin,
   input  wire logic                      decel_pin,
   input  wire logic                      devack_pin,
   input  wire logic [`ACSW_ADDR_W-1:0]   addr,
   input  wire logic [15:0]               wdata,
   input  wire logic                      wr,
   input  wire logic                      rd,
   output logic [15:0]                    rdata_q,
   output logic                           start_accept_q,
   output logic                           irq_q
);
   import acsw_pkg::*;

   // pin synchronisers: stage 1 feeds only stage 2
   logic [2:0] pin_s1_q;
   logic [2:0] pin_s2_q;
   logic       estop_s;
   logic       decel_s;
   logic       devack_s;

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         pin_s1_q <= 3'h0;
         pin_s2_q <= 3'h0;
      end else begin
         pin_s1_q <= {devack_pin, decel_pin, estop_pin};
         pin_s2_q <= pin_s1_q;
      end
   end
   assign estop_s  = pin_s2_q[0];
   assign decel_s  = pin_s2_q[1];
   assign devack_s = pin_s2_q[2];

   // status state
   logic            stop_q,     stop_d;
   logic            grp_hold_q, grp_hold_d;
   logic            all_hold_q, all_hold_d;
   logic            hsptp_q,    hsptp_d;
   logic            inv_q,      inv_d;
   logic            devf_q,     devf_d;
   logic            sexec_q,    sexec_d;
   logic            pdone_q,    pdone_d;
   logic            acc_d;
   acsw_ack_state_t ack_st_q,   ack_st_d;
   logic [31:0]     ack_cnt_q,  ack_cnt_d;
   logic            stop_set, start_bad, start_ok, devf_set, sexec_set, pdone_set;

   always_comb begin
      stop_set  = ev.imm_stop_cmd | ev.dec_stop_cmd | estop_s | decel_s;      // RULE_05
      start_bad = ev.cond_fail | ev.start_error | ev.prio_conflict;
      start_ok  = ev.start_req & !stop_q & !start_bad;                        // RULE_06
      acc_d     = start_ok;
      // a latched stop clears only once the axis is idle and no source remains
      stop_d    = stop_set | (stop_q & motion.busy);
      grp_hold_d = (motion.grp_stop_bit & motion.sys_stopped)                 // RULE_07
                   | (grp_hold_q & !start_ok);
      all_hold_d = (motion.all_stop_bit & motion.sys_stopped)                 // RULE_08
                   | (all_hold_q & !start_ok);
      // event bits clear when a new start is taken; a new set wins
      hsptp_d   = (start_ok & ev.hs_ptp) | (hsptp_q & !(ev.start_req & !stop_q)); // RULE_09
      inv_d     = (ev.start_req & !stop_q & start_bad)                        // RULE_10 RULE_11
                  | (inv_q & !start_ok);
      sexec_set = ev.halted & ((motion.manual_mode | motion.direct_mode)      // RULE_13
                  & (ev.halt_decel | ev.halt_dev_reset | ev.halt_servo_unlock)
                  | ev.halt_error);                                           // RULE_14
      sexec_d   = sexec_set | (sexec_q & !start_ok);
      pdone_set = motion.direct_mode & ((ev.move_done & (ev.done_positioning  // RULE_15
                  | ev.done_origin_search | ev.done_origin_return))
                  | ev.jog_stopped);                                          // RULE_16
      pdone_d   = pdone_set | (pdone_q & !start_ok);
      // deviation reset acknowledge watchdog
      ack_st_d  = ack_st_q;
      ack_cnt_d = ack_cnt_q;
      devf_set  = 1'b0;
      unique case (ack_st_q)
         ACSW_ACK_IDLE: begin
            if (ev.dev_reset_out && motion.origin_search) begin
               ack_st_d  = ACSW_ACK_WAIT;
               ack_cnt_d = 32'h0;
            end
         end
         ACSW_ACK_WAIT: begin
            if (devack_s || !motion.origin_search) begin
               ack_st_d = ACSW_ACK_IDLE;
            end else if (ack_cnt_q == DEVACK_CYC - 1) begin
               ack_st_d = ACSW_ACK_IDLE;
               devf_set = 1'b1;                                               // RULE_12
            end else begin
               ack_cnt_d = ack_cnt_q + 32'h1;
            end
         end
      endcase
      devf_d = devf_set | (devf_q & !(ev.dev_reset_out && motion.origin_search));
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         stop_q         <= 1'b0;
         grp_hold_q     <= 1'b0;
         all_hold_q     <= 1'b0;
         hsptp_q        <= 1'b0;
         inv_q          <= 1'b0;
         devf_q         <= 1'b0;
         sexec_q        <= 1'b0;
         pdone_q        <= 1'b0;
         start_accept_q <= 1'b0;
         ack_st_q       <= ACSW_ACK_IDLE;
         ack_cnt_q      <= 32'h0;
      end else begin
         stop_q         <= stop_d;
         grp_hold_q     <= grp_hold_d;
         all_hold_q     <= all_hold_d;
         hsptp_q        <= hsptp_d;
         inv_q          <= inv_d;
         devf_q         <= devf_d;
         sexec_q        <= sexec_d;
         pdone_q        <= pdone_d;
         start_accept_q <= acc_d;
         ack_st_q       <= ack_st_d;
         ack_cnt_q      <= ack_cnt_d;
      end
   end

   // live status image; level bits follow the engine without delay
   acsw_status_t st;
   always_comb begin
      st             = acsw_status_t'(`ACSW_STATUS_RESET);                   // RULE_17
      st.busy        = motion.busy | (motion.memory_op & !motion.axis_assigned); // RULE_01 RULE_02
      st.jog_ok      = motion.jog_ok;                                         // RULE_03
      st.direct_ok   = motion.direct_ok;                                      // RULE_04
      st.stop_in     = stop_q;
      st.grp_stop    = motion.grp_stop_bit | grp_hold_q;                      // RULE_07
      st.all_stop    = motion.all_stop_bit | all_hold_q;                      // RULE_08
      st.hsptp_ack   = hsptp_q;
      st.start_inv   = inv_q;
      st.devack_fail = devf_q;
      st.stop_exec   = sexec_q;
      st.pos_done    = pdone_q;
   end

   // interrupt status: rising edges of event bits, write one to clear
   logic [`ACSW_IRQ_W-1:0] ist_q, ist_d;
   logic [`ACSW_IRQ_W-1:0] imask_q, imask_d;
   logic [`ACSW_IRQ_W-1:0] ev_now, ev_prev_q;
   logic [15:0]            rdata_d;
   logic                   irq_d;

   // one address decode shared by both register write strobes
   function automatic logic reg_hit(input logic                    s,
                                    input logic [`ACSW_ADDR_W-1:0] a,
                                    input logic [`ACSW_ADDR_W-1:0] o);
      reg_hit = s && (a == o);
   endfunction

   always_comb begin
      ev_now = {stop_q, hsptp_q, pdone_q, sexec_q, devf_q, inv_q};
      // set beats a clear landing in the same cycle
      ist_d  = ist_q;
      if (reg_hit(wr, addr, `ACSW_ADDR_IRQ_STAT)) begin
         ist_d = ist_q & ~wdata[`ACSW_IRQ_W-1:0];
      end
      ist_d   = ist_d | (ev_now & ~ev_prev_q);
      imask_d = imask_q;
      if (reg_hit(wr, addr, `ACSW_ADDR_IRQ_MASK)) begin
         imask_d = wdata[`ACSW_IRQ_W-1:0];
      end
      irq_d   = |(ist_d & imask_d);
      rdata_d = 16'h0000;
      if (rd) begin
         unique case (addr)
            `ACSW_ADDR_STATUS:   rdata_d = st;
            `ACSW_ADDR_IRQ_STAT: rdata_d = {10'h000, ist_q};
            `ACSW_ADDR_IRQ_MASK: rdata_d = {10'h000, imask_q};
            default:             rdata_d = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         ist_q     <= `ACSW_IRQ_RESET;
         imask_q   <= `ACSW_IRQ_RESET;
         ev_prev_q <= `ACSW_IRQ_RESET;
         irq_q     <= 1'b0;
         rdata_q   <= 16'h0000;
      end else begin
         ist_q     <= ist_d;
         imask_q   <= imask_d;
         ev_prev_q <= ev_now;
         irq_q     <= irq_d;
         rdata_q   <= rdata_d;
      end
   end

   // checks
   sequence s_stop_cmd;
      ev.imm_stop_cmd || ev.dec_stop_cmd;
   endsequence
   sequence s_status_read;
      rd && addr == `ACSW_ADDR_STATUS;
   endsequence
   sequence s_start_taken;
      ev.start_req && !stop_q;
   endsequence
   sequence s_start_clean;
      s_start_taken ##0 !(ev.cond_fail || ev.start_error || ev.prio_conflict);
   endsequence
   sequence s_pin_stop;
      estop_s || decel_s;
   endsequence
   sequence s_grp_held;
      motion.grp_stop_bit && motion.sys_stopped;
   endsequence
   sequence s_all_held;
      motion.all_stop_bit && motion.sys_stopped;
   endsequence
   sequence s_dev_arm;
      ev.dev_reset_out && motion.origin_search && ack_st_q == ACSW_ACK_IDLE;
   endsequence
   sequence s_hand_halt;
      ev.halted && (motion.manual_mode || motion.direct_mode);
   endsequence
   sequence s_direct_done;
      motion.direct_mode && ev.move_done;
   endsequence

   stop_latch_a: assert property (@(posedge clock) disable iff (!rstn) // RULE_05
      s_stop_cmd |=> stop_q) else $error("stop flag not set by stop command");
   start_block_a: assert property (@(posedge clock) disable iff (!rstn) // RULE_06
      stop_q |=> !start_accept_q) else $error("start taken while stop flag set");
   busy_read_a: assert property (@(posedge clock) disable iff (!rstn) // RULE_01
      s_status_read ##0 motion.busy |=> rdata_q[`ACSW_B_BUSY])
      else $error("busy not reported");
   memop_busy_a: assert property (@(posedge clock) disable iff (!rstn) // RULE_02
      s_status_read ##0 (motion.memory_op && !motion.axis_assigned)
      |=> rdata_q[`ACSW_B_BUSY]) else $error("unassigned axis not busy");
   unused_zero_a: assert property (@(posedge clock) disable iff (!rstn) // RULE_17
      {rdata_q[15:14], rdata_q[11:10], rdata_q[3]} == 5'h00)
      else $error("unused status bit set");
   hsptp_ack_a: assert property (@(posedge clock) disable iff (!rstn) // RULE_09
      start_ok && ev.hs_ptp |=> hsptp_q && start_accept_q)
      else $error("high speed start not acknowledged");
   inv_set_a: assert property (@(posedge clock) disable iff (!rstn) // RULE_10
      ev.start_req && !stop_q && ev.cond_fail |=> inv_q && !start_accept_q)
      else $error("invalid start not flagged");
   devack_to_a: assert property (@(posedge clock) disable iff (!rstn) // RULE_12
      $rose(devf_q) |-> $past(ack_st_q) == ACSW_ACK_WAIT && !$past(devack_s))
      else $error("deviation ack failure without timeout");
   stop_exec_a: assert property (@(posedge clock) disable iff (!rstn) // RULE_14
      ev.halted && ev.halt_error |=> sexec_q) else $error("error halt not flagged");
   pos_done_a: assert property (@(posedge clock) disable iff (!rstn) // RULE_16
      motion.direct_mode && ev.jog_stopped |=> pdone_q)
      else $error("jog stop not flagged");
   irq_out_a: assert property (@(posedge clock) disable iff (!rstn)
      |(ist_q & imask_q) |-> irq_q) else $error("interrupt not raised");

   // level bits of the status word, as seen at the read strobe
   jog_read_a: assert property (@(posedge clock) disable iff (!rstn) // RULE_03
      s_status_read |=> rdata_q[`ACSW_B_JOG_OK] == $past(motion.jog_ok))
      else $error("jog enable not reported");
   direct_read_a: assert property (@(posedge clock) disable iff (!rstn) // RULE_04
      s_status_read |=> rdata_q[`ACSW_B_DIRECT_OK] == $past(motion.direct_ok))
      else $error("direct enable not reported");
   grp_level_a: assert property (@(posedge clock) disable iff (!rstn) // RULE_07
      s_status_read ##0 motion.grp_stop_bit |=> rdata_q[`ACSW_B_GRP_STOP])
      else $error("group stop level not reported");
   all_level_a: assert property (@(posedge clock) disable iff (!rstn) // RULE_08
      s_status_read ##0 motion.all_stop_bit |=> rdata_q[`ACSW_B_ALL_STOP])
      else $error("all stop level not reported");

   // stop flag and its effect on starts
   stop_read_a: assert property (@(posedge clock) disable iff (!rstn) // RULE_05
      s_status_read |=> rdata_q[`ACSW_B_STOP_IN] == $past(stop_q))
      else $error("stop flag not reported");
   pin_stop_a: assert property (@(posedge clock) disable iff (!rstn) // RULE_05
      s_pin_stop |=> stop_q) else $error("stop pin not latched");
   stop_hold_a: assert property (@(posedge clock) disable iff (!rstn) // RULE_05
      stop_q && motion.busy |=> stop_q) else $error("stop flag dropped while busy");
   clean_start_a: assert property (@(posedge clock) disable iff (!rstn) // RULE_06
      s_start_clean |=> start_accept_q) else $error("clean start not taken");
   refused_keep_a: assert property (@(posedge clock) disable iff (!rstn) // RULE_06
      stop_q && ev.start_req |=> $stable(inv_q) && $stable(hsptp_q))
      else $error("refused start changed status");

   // held stop images
   grp_hold_a: assert property (@(posedge clock) disable iff (!rstn) // RULE_07
      s_grp_held |=> grp_hold_q) else $error("group stop not held");
   all_hold_a: assert property (@(posedge clock) disable iff (!rstn) // RULE_08
      s_all_held |=> all_hold_q) else $error("all stop not held");

   // start acknowledge and start invalid
   hsptp_read_a: assert property (@(posedge clock) disable iff (!rstn) // RULE_09
      s_status_read |=> rdata_q[`ACSW_B_HSPTP_ACK] == $past(hsptp_q))
      else $error("high speed ack not reported");
   hsptp_clear_a: assert property (@(posedge clock) disable iff (!rstn) // RULE_09
      s_start_taken ##0 !ev.hs_ptp |=> !hsptp_q)
      else $error("high speed ack not cleared");
   inv_read_a: assert property (@(posedge clock) disable iff (!rstn) // RULE_10
      s_status_read |=> rdata_q[`ACSW_B_START_INV] == $past(inv_q))
      else $error("start invalid not reported");
   start_err_a: assert property (@(posedge clock) disable iff (!rstn) // RULE_11
      s_start_taken ##0 (ev.start_error || ev.prio_conflict) |=> inv_q && !start_accept_q)
      else $error("start error not flagged");
   inv_clear_a: assert property (@(posedge clock) disable iff (!rstn)
      s_start_clean |=> !inv_q) else $error("start invalid not cleared");

   // deviation reset acknowledge watchdog
   devack_arm_a: assert property (@(posedge clock) disable iff (!rstn) // RULE_12
      s_dev_arm |=> ack_st_q == ACSW_ACK_WAIT && !devf_q)
      else $error("acknowledge wait not armed");
   devack_end_a: assert property (@(posedge clock) disable iff (!rstn) // RULE_12
      ack_st_q == ACSW_ACK_WAIT && devack_s |=> ack_st_q == ACSW_ACK_IDLE && !devf_q)
      else $error("acknowledge did not end wait");
   devack_time_a: assert property (@(posedge clock) disable iff (!rstn) // RULE_12
      ack_st_q == ACSW_ACK_WAIT && ack_cnt_q == DEVACK_CYC - 1
      && !devack_s && motion.origin_search |=> devf_q)
      else $error("acknowledge timeout not flagged");
   devack_read_a: assert property (@(posedge clock) disable iff (!rstn) // RULE_12
      s_status_read |=> rdata_q[`ACSW_B_DEVACK_FAIL] == $past(devf_q))
      else $error("acknowledge failure not reported");

   // stop executed and positioning completed
   hand_halt_a: assert property (@(posedge clock) disable iff (!rstn) // RULE_13
      s_hand_halt ##0 (ev.halt_decel || ev.halt_dev_reset || ev.halt_servo_unlock)
      |=> sexec_q) else $error("manual halt not flagged");
   sexec_read_a: assert property (@(posedge clock) disable iff (!rstn) // RULE_13
      s_status_read |=> rdata_q[`ACSW_B_STOP_EXEC] == $past(sexec_q))
      else $error("stop executed not reported");
   direct_done_a: assert property (@(posedge clock) disable iff (!rstn) // RULE_15
      s_direct_done ##0 (ev.done_positioning || ev.done_origin_search
      || ev.done_origin_return) |=> pdone_q) else $error("move finish not flagged");
   pdone_read_a: assert property (@(posedge clock) disable iff (!rstn) // RULE_15
      s_status_read |=> rdata_q[`ACSW_B_POS_DONE] == $past(pdone_q))
      else $error("positioning done not reported");

   // interrupt and read port
   pos_irq_a: assert property (@(posedge clock) disable iff (!rstn)
      $rose(pdone_q) |=> ist_q[`ACSW_I_POS_DONE])
      else $error("positioning done interrupt not set");
   irq_low_a: assert property (@(posedge clock) disable iff (!rstn)
      (ist_q & imask_q) == '0 |-> !irq_q)
      else $error("interrupt raised with nothing pending");
   idle_rdata_a: assert property (@(posedge clock) disable iff (!rstn)
      !rd |=> rdata_q == 16'h0000)
      else $error("read data outside read cycle");
   unmapped_rd_a: assert property (@(posedge clock) disable iff (!rstn)
      rd && !(addr inside {`ACSW_ADDR_STATUS, `ACSW_ADDR_IRQ_STAT, `ACSW_ADDR_IRQ_MASK})
      |=> rdata_q == 16'h0000) else $error("unmapped read not zero");

endmodule

// *** dv/acsw_host.sv ***
`timescale 1ns/1ns
`include "acsw_defines.svh"
module acsw_host (
   input  wire logic                    clock,
   output logic [`ACSW_ADDR_W-1:0]      addr,
   output logic [15:0]                  wdata,
   output logic                         wr,
   output logic                         rd
);
   initial begin
      addr = '0;
      wdata = 16'h0000;
      wr = 1'b0;
      rd = 1'b0;
   end
   // one strobe cycle, then one quiet edge so a strobe is never set twice in one step
   task automatic access(input logic w, input logic [`ACSW_ADDR_W-1:0] a, input logic [15:0] d);
      addr <= a;
      wdata <= d;
      wr <= w;
      rd <= ~w;
      @(posedge clock);
      wr <= 1'b0;
      rd <= 1'b0;
      // an idle bus shows the inverse, never the stale value
      addr <= ~a;
      wdata <= ~d;
      @(posedge clock);
   endtask
endmodule

// *** dv/test_axis_command_status_word.sv ***
`timescale 1ns/1ns
`include "acsw_defines.svh"
module test_axis_command_status_word;
   import acsw_pkg::*;
   localparam int unsigned DEV_CYC = 20;
   logic                    clock = 1'b0;
   logic                    rstn = 1'b0;
   acsw_motion_t            motion = '0;
   acsw_event_t             ev = '0;
   acsw_event_t             e;
   logic                    estop_pin = 1'b0;
   logic                    decel_pin = 1'b0;
   logic                    devack_pin = 1'b0;
   logic [`ACSW_ADDR_W-1:0] addr;
   logic [15:0]             wdata;
   logic                    wr;
   logic                    rd;
   logic [15:0]             rdata_q;
   logic                    start_accept_q;
   logic                    irq_q;
   logic                    rd_p = 1'b0;
   logic [15:0]             sticky = 16'h0000;
   logic [15:0]             exp_q[$];
   int                      fail_count = 0;
   int                      tests_run = 0;
   int                      seed = 32'he372a0f8;
   int                      k;
   always #2 clock = ~clock;
   acsw_top #(.DEVACK_CYC(DEV_CYC)) i_acsw_top (
      .clock          (clock),
      .rstn           (rstn),
      .motion         (motion),
      .ev             (ev),
      .estop_pin      (estop_pin),
      .decel_pin      (decel_pin),
      .devack_pin     (devack_pin),
      .addr           (addr),
      .wdata          (wdata),
      .wr             (wr),
      .rd             (rd),
      .rdata_q        (rdata_q),
      .start_accept_q (start_accept_q),
      .irq_q          (irq_q)
   );
   acsw_host i_acsw_host (
      .clock (clock),
      .addr  (addr),
      .wdata (wdata),
      .wr    (wr),
      .rd    (rd)
   );
   task automatic check(input string what, input logic [15:0] ex, input logic [15:0] s);
      tests_run++;
      if (s !== ex) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", what, ex, s);
      end
   endtask
   // read data stand only in the cycle after the strobe, zero elsewhere
   always @(posedge clock) begin
      if (rd_p) begin
         if (exp_q.size() == 0) check("read note", 16'h0001, 16'h0000);
         else check("rdata_q", exp_q.pop_front(), rdata_q);
      end else if (rstn) begin
         check("idle rdata_q", 16'h0000, rdata_q);
      end
      rd_p <= rd;
   end
   task automatic rd_exp(input logic [7:0] a, input logic [15:0] ex);
      exp_q.push_back(ex);
      i_acsw_host.access(1'b0, a, 16'h0000);
   endtask
   function automatic logic [15:0] live();
      live = sticky;
      live[0] = motion.busy | (motion.memory_op & ~motion.axis_assigned);
      live[1] = motion.jog_ok;
      live[2] = motion.direct_ok;
      live[5] = sticky[5] | motion.grp_stop_bit;
      live[6] = sticky[6] | motion.all_stop_bit;
   endfunction
   task automatic pulse(input acsw_event_t p);
      ev <= p;
      @(posedge clock);
      ev <= '0;
      @(posedge clock);
   endtask
   // mode 0 ignored under a stop, 1 taken, 2 refused as invalid
   task automatic start(input acsw_event_t p, input int mode);
      p.start_req = 1'b1;
      ev <= p;
      @(posedge clock);
      ev <= '0;
      @(negedge clock);
      check("start_accept_q", {15'h0, mode == 1}, {15'h0, start_accept_q});
      @(posedge clock);
      if (mode == 1) sticky &= 16'hce1f;
      if (mode != 0) sticky[7] = (mode == 1) & p.hs_ptp;
      if (mode == 2) sticky[8] = 1'b1;
   endtask
   task automatic irq_is(input logic v);
      @(negedge clock);
      check("irq_q", {15'h0, v}, {15'h0, irq_q});
      @(posedge clock);
   endtask
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge clock);
      rstn <= 1'b1;
      @(posedge clock);
      rd_exp(8'h02, 16'h0000);
      rd_exp(8'h11, 16'h0000);
      wr_reg_blk: i_acsw_host.access(1'b1, 8'h02, 16'hffff);
      rd_exp(8'h33, 16'h0000);
      rd_exp(8'h02, 16'h0000);
      for (k = 0; k < 12; k++) begin
         motion <= acsw_motion_t'(11'($random(seed)) & 11'h7f6);
         @(posedge clock);
         rd_exp(8'h02, live());
      end
      motion <= '0;
      e = '0;
      e.cond_fail = 1'b1;
      for (k = 0; k < 4; k++) begin
         motion <= acsw_motion_t'(11'h400);
         ev.imm_stop_cmd <= (k == 0);
         ev.dec_stop_cmd <= (k == 1);
         estop_pin <= (k == 2);
         decel_pin <= (k == 3);
         @(posedge clock);
         ev <= '0;
         repeat (5) @(posedge clock);
         sticky[4] = 1'b1;
         rd_exp(8'h02, live());
         start(e, 0);
         rd_exp(8'h02, live());
         motion <= '0;
         estop_pin <= 1'b0;
         decel_pin <= 1'b0;
         repeat (5) @(posedge clock);
         sticky[4] = 1'b0;
         rd_exp(8'h02, live());
      end
      for (k = 0; k < 3; k++) begin
         start('0, 1);
         e = '0;
         e.cond_fail = (k == 0);
         e.start_error = (k == 1);
         e.prio_conflict = (k == 2);
         start(e, 2);
         rd_exp(8'h02, live());
      end
      e = '0;
      e.hs_ptp = 1'b1;
      start(e, 1);
      rd_exp(8'h02, live());
      for (k = 0; k < 5; k++) begin
         start('0, 1);
         motion <= acsw_motion_t'({5'h00, k < 2, k == 2 || k == 3, 4'h0});
         e = '0;
         e.halted = 1'b1;
         e.halt_decel = (k == 0) | (k == 4);
         e.halt_dev_reset = (k == 1);
         e.halt_servo_unlock = (k == 2);
         e.halt_error = (k == 3);
         pulse(e);
         sticky[12] = (k < 4);
         rd_exp(8'h02, live());
      end
      for (k = 0; k < 5; k++) begin
         start('0, 1);
         motion <= acsw_motion_t'({5'h00, k == 4, k < 4, 4'h0});
         e = '0;
         e.move_done = (k != 3);
         e.done_positioning = (k == 0) | (k == 4);
         e.done_origin_search = (k == 1);
         e.done_origin_return = (k == 2);
         e.jog_stopped = (k == 3);
         pulse(e);
         sticky[13] = (k < 4);
         rd_exp(8'h02, live());
      end
      motion <= acsw_motion_t'(11'h008);
      e = '0;
      e.dev_reset_out = 1'b1;
      pulse(e);
      repeat (DEV_CYC - 4) @(posedge clock);
      rd_exp(8'h02, live());
      repeat (2) @(posedge clock);
      sticky[9] = 1'b1;
      rd_exp(8'h02, live());
      pulse(e);
      devack_pin <= 1'b1;
      repeat (DEV_CYC + 2) @(posedge clock);
      sticky[9] = 1'b0;
      rd_exp(8'h02, live());
      devack_pin <= 1'b0;
      motion <= acsw_motion_t'(11'h007);
      repeat (3) @(posedge clock);
      motion <= '0;
      @(posedge clock);
      sticky[6:5] = 2'b11;
      rd_exp(8'h02, live());
      start('0, 1);
      rd_exp(8'h02, live());
      i_acsw_host.access(1'b1, 8'h10, 16'h003f);
      irq_is(1'b0);
      e = '0;
      e.start_error = 1'b1;
      start(e, 2);
      rd_exp(8'h10, 16'h0001);
      irq_is(1'b0);
      i_acsw_host.access(1'b1, 8'h11, 16'h0001);
      irq_is(1'b1);
      rd_exp(8'h11, 16'h0001);
      i_acsw_host.access(1'b1, 8'h10, 16'h0001);
      irq_is(1'b0);
      rd_exp(8'h10, 16'h0000);
      repeat (3) @(posedge clock);
      check("pending reads", 16'h0000, 16'(exp_q.size()));
      test_done();
   end
endmodule
